// *** src/csm_pkg.sv ***
/*
 * Shared constants and types of the core map block: special function
 * addresses, status word fields, data memory regions, flash range,
 * operation codes and instruction costs.
 * Assumes one 8-bit core issuing one operation at a time.
 */
package csm_pkg;

    localparam logic [7:0] CSM_PORT0_LATCH         = 8'h80;
    localparam logic [7:0] CSM_STACK_POINTER       = 8'h81;
    localparam logic [7:0] CSM_DATA_POINTER_LOW    = 8'h82;
    localparam logic [7:0] CSM_DATA_POINTER_HIGH   = 8'h83;
    localparam logic [7:0] CSM_RESERVED_SLOT       = 8'h84;
    localparam logic [7:0] CSM_POWER_CONTROL       = 8'h87;
    localparam logic [7:0] CSM_TIMER_CONTROL       = 8'h88;
    localparam logic [7:0] CSM_TIMER_MODE_SELECT   = 8'h89;
    localparam logic [7:0] CSM_TIMER0_COUNT_LOW    = 8'h8A;
    localparam logic [7:0] CSM_TIMER1_COUNT_LOW    = 8'h8B;
    localparam logic [7:0] CSM_TIMER0_COUNT_HIGH   = 8'h8C;
    localparam logic [7:0] CSM_TIMER1_COUNT_HIGH   = 8'h8D;
    localparam logic [7:0] CSM_PORT1_LATCH         = 8'h90;
    localparam logic [7:0] CSM_SERIAL_CONTROL      = 8'h98;
    localparam logic [7:0] CSM_SERIAL_BUFFER       = 8'h99;
    localparam logic [7:0] CSM_WATCHDOG_CONTROL    = 8'h9F;
    localparam logic [7:0] CSM_PORT2_LATCH         = 8'hA0;
    localparam logic [7:0] CSM_INTERRUPT_ENABLE    = 8'hA8;
    localparam logic [7:0] CSM_PORT3_LATCH         = 8'hB0;
    localparam logic [7:0] CSM_INTERRUPT_PRIORITY  = 8'hB8;
    localparam logic [7:0] CSM_SYSTEM_CONFIG       = 8'hBF;
    localparam logic [7:0] CSM_TIMER2_CONTROL      = 8'hC8;
    localparam logic [7:0] CSM_TIMER2_RELOAD_HIGH  = 8'hCA;
    localparam logic [7:0] CSM_TIMER2_RELOAD_LOW   = 8'hCB;
    localparam logic [7:0] CSM_TIMER2_COUNT_LOW    = 8'hCC;
    localparam logic [7:0] CSM_PROGRAM_STATUS_WORD = 8'hD0;
    localparam logic [7:0] CSM_PRIMARY_OPERAND_REG = 8'hE0;
    localparam logic [7:0] CSM_SECOND_OPERAND_REG  = 8'hF0;

    // Storage slots, in address order; the reserved slot has none.
    localparam int CSM_NSFR = 27;
    localparam logic [7:0] CSM_SFR_MAP [CSM_NSFR] = '{
        CSM_PORT0_LATCH, CSM_STACK_POINTER, CSM_DATA_POINTER_LOW,
        CSM_DATA_POINTER_HIGH, CSM_POWER_CONTROL, CSM_TIMER_CONTROL,
        CSM_TIMER_MODE_SELECT, CSM_TIMER0_COUNT_LOW, CSM_TIMER1_COUNT_LOW,
        CSM_TIMER0_COUNT_HIGH, CSM_TIMER1_COUNT_HIGH, CSM_PORT1_LATCH,
        CSM_SERIAL_CONTROL, CSM_SERIAL_BUFFER, CSM_WATCHDOG_CONTROL,
        CSM_PORT2_LATCH, CSM_INTERRUPT_ENABLE, CSM_PORT3_LATCH,
        CSM_INTERRUPT_PRIORITY, CSM_SYSTEM_CONFIG, CSM_TIMER2_CONTROL,
        CSM_TIMER2_RELOAD_HIGH, CSM_TIMER2_RELOAD_LOW, CSM_TIMER2_COUNT_LOW,
        CSM_PROGRAM_STATUS_WORD, CSM_PRIMARY_OPERAND_REG,
        CSM_SECOND_OPERAND_REG};
    localparam logic [4:0] SLOT_DPL = 5'h02;
    localparam logic [4:0] SLOT_DPH = 5'h03;
    localparam logic [4:0] SLOT_PSW = 5'h18;
    localparam logic [4:0] SLOT_ACC = 5'h19;
    localparam logic [7:0] CSM_SFR_RESET = 8'h00;

    // Status word fields.
    localparam int PSW_CY  = 7;
    localparam int PSW_AC  = 6;
    localparam int PSW_F0  = 5;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_OV  = 2;
    localparam int PSW_P   = 0;

    // Data memory regions and program flash range.
    localparam logic [7:0]  CSM_BIT_BASE  = 8'h20;
    localparam logic [7:0]  CSM_BIT_TOP   = 8'h2F;
    localparam logic [15:0] CSM_FLASH_TOP = 16'h1FFF;

    typedef enum logic [3:0] {
        OP_RD, OP_WR, OP_BSET, OP_BCLR, OP_BCPL, OP_BTST, OP_ADD,
        OP_JBC, OP_NIBBLE_EXCHANGE_OP, OP_DECREMENT_JUMP_NONZERO, OP_COMPARE_JUMP_UNEQUAL, OP_JMPI, OP_LONG_CALL_OP, OP_INTERRUPT_RETURN_OP
    } csm_op_t;

    typedef enum logic [1:0] {M_DIR, M_IND, M_REG} csm_mode_t;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_HOLD = 2'b01} csm_state_t;

    // Cost as {bytes[3:2], cycles[1:0]}; plain accesses are one cycle.
    function automatic logic [3:0] csm_cost(input csm_op_t op);
        case (op)
            OP_INTERRUPT_RETURN_OP, OP_JMPI:          return 4'h6;
            OP_LONG_CALL_OP, OP_JBC, OP_COMPARE_JUMP_UNEQUAL: return 4'hE;
            OP_NIBBLE_EXCHANGE_OP:                   return 4'h5;
            OP_DECREMENT_JUMP_NONZERO:                   return 4'hA;
            default:                   return 4'h1;
        endcase
    endfunction : csm_cost

endpackage : csm_pkg

// *** src/csm_core_map.sv ***
/*
 * Address decoding and status state of the 8-bit core: internal data
 * RAM, special function registers, bank and bit mapping, status word,
 * data pointer, flash fetch range and the branch/exchange operations.
 * Assumes the sequencer issues one request at a time while busy_r is low.
 */
`timescale 1ns/1ps

module csm_core_map (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Operation request
    input  wire logic                  req_valid,
    input  wire csm_pkg::csm_op_t      req_op,
    input  wire csm_pkg::csm_mode_t    req_mode,
    input  wire logic [7:0]            req_addr,
    input  wire logic [2:0]            req_reg,
    input  wire logic [7:0]            req_bit,
    input  wire logic [7:0]            req_wdata,
    input  wire logic [7:0]            req_rel,
    input  wire logic [15:0]           req_pc,
    input  wire logic [15:0]           req_target,
    // Operation result
    output logic                       busy_r,
    output logic                       done_r,
    output logic [7:0]                 rdata_r,
    output logic                       branch_r,
    output logic [15:0]                target_r,
    output logic [1:0]                 op_bytes_r,
    output logic [1:0]                 op_cycles_r,
    // Program fetch
    input  wire logic                  fetch_req,
    input  wire logic [15:0]           fetch_addr,
    output logic                       flash_sel_r,
    output logic                       fetch_fault_r
);
    import csm_pkg::*;

    logic [7:0] ram_r [256];
    logic [7:0] sfr_r [CSM_NSFR];
    csm_state_t state_r;

    // Returns {hit, slot} for a special address; misses map to no storage.
    function automatic logic [5:0] sfr_slot(input logic [7:0] a);
        logic [5:0] s;
        s = 6'h00;
        for (int i = 0; i < CSM_NSFR; i++) begin
            if (CSM_SFR_MAP[i] == a) begin
                s = {1'b1, 5'(i)};
            end
        end
        return s;
    endfunction : sfr_slot

    // Read view of one slot: misses read zero, the status word shows parity.
    function automatic logic [7:0] sfr_view(input logic [5:0] s,
                                            input logic [7:0] v,
                                            input logic [7:0] program_status_word);
        if (!s[5]) begin
            return 8'h00;
        end
        return (s[4:0] == SLOT_PSW) ? program_status_word : v;
    endfunction : sfr_view

    wire logic       take     = req_valid && state_r == ST_IDLE;
    wire logic [7:0] acc_w    = sfr_r[SLOT_ACC];
    wire logic [7:0] psw_w    = sfr_r[SLOT_PSW];
    wire logic [1:0] bank_w   = {psw_w[PSW_RS1], psw_w[PSW_RS0]};
    // Parity is derived live, so a write to bit 0 is stored but never read back.
    wire logic [7:0] psw_view = {psw_w[7:1], ^acc_w};

    // Working registers and @Ri pointers live in the active bank.
    wire logic [7:0] reg_at = {3'b000, bank_w, req_reg};
    wire logic [7:0] ptr_at = {3'b000, bank_w, 2'b00, req_reg[0]};
    wire logic [7:0] ind_at = ram_r[ptr_at];

    // Of the byte accesses, only a direct one with bit 7 set selects the special space; bit operands use req_bit[7].
    wire logic       dir_sfr = req_mode == M_DIR && req_addr[7];
    wire logic [5:0] dslot   = sfr_slot(req_addr);
    wire logic [7:0] sfr_val = sfr_view(dslot, sfr_r[dslot[4:0]], psw_view);
    // Indirect reaches all 256 bytes, direct only the lower half.
    wire logic [7:0] ram_at = (req_mode == M_IND) ? ind_at :
                              (req_mode == M_REG) ? reg_at :
                              req_addr;
    wire logic [7:0] opnd   = dir_sfr ? sfr_val : ram_r[ram_at];

    // Bit addresses below 80h land in 20h-2Fh and nowhere else.
    wire logic       bit_sfr  = req_bit[7];
    wire logic [7:0] bit_byte = bit_sfr ? {req_bit[7:3], 3'b000} :
                                CSM_BIT_BASE + {4'h0, req_bit[6:3]};
    wire logic [5:0] bslot    = sfr_slot(bit_byte);
    wire logic [7:0] bit_word = bit_sfr ?
                                sfr_view(bslot, sfr_r[bslot[4:0]], psw_view) :
                                ram_r[bit_byte];
    wire logic       bit_val  = bit_word[req_bit[2:0]];
    wire logic [7:0] bit_mask = 8'h01 << req_bit[2:0];

    wire logic [8:0]  sum    = {1'b0, acc_w} + {1'b0, opnd};
    wire logic [4:0]  lo_sum = {1'b0, acc_w[3:0]} + {1'b0, opnd[3:0]};
    wire logic        ov     = acc_w[7] == opnd[7] && sum[7] != acc_w[7];
    wire logic [7:0]  dec    = ram_r[reg_at] - 8'h01;
    wire logic [15:0] rel_tg = req_pc + {{8{req_rel[7]}}, req_rel};
    wire logic [15:0] data_pointer16   = {sfr_r[SLOT_DPH], sfr_r[SLOT_DPL]};
    wire logic [3:0]  cost   = csm_cost(req_op);

    logic       ram_we, sfr_we, acc_we, psw_we, br_nxt;
    logic [7:0] ram_wa, ram_wd, sfr_wd, acc_wd, psw_wd, rdata_nxt;
    logic [4:0] sfr_ws;
    logic [15:0] tgt_nxt;

    always_comb begin
        ram_we = 1'b0;
        ram_wa = ram_at;
        ram_wd = req_wdata;
        sfr_we = 1'b0;
        sfr_ws = dslot[4:0];
        sfr_wd = req_wdata;
        acc_we = 1'b0;
        acc_wd = acc_w;
        psw_we = 1'b0;
        psw_wd = psw_w;
        br_nxt = 1'b0;
        tgt_nxt = target_r;
        rdata_nxt = opnd;
        case (req_op)
            OP_WR: begin
                // Misses in the special space are dropped.
                sfr_we = dir_sfr && dslot[5];
                ram_we = !dir_sfr;
            end
            OP_BSET, OP_BCLR, OP_BCPL, OP_BTST, OP_JBC: begin
                rdata_nxt = {7'h00, bit_val};
                case (req_op)
                    OP_BSET: sfr_wd = bit_word | bit_mask;
                    OP_BCPL: sfr_wd = bit_word ^ bit_mask;
                    default: sfr_wd = bit_word & ~bit_mask;
                endcase
                ram_wd = sfr_wd;
                ram_wa = bit_byte;
                sfr_ws = bslot[4:0];
                if (req_op != OP_BTST && (req_op != OP_JBC || bit_val)) begin
                    sfr_we = bit_sfr && bslot[5];
                    ram_we = !bit_sfr;
                end
                if (req_op == OP_JBC) begin
                    br_nxt = bit_val;
                    tgt_nxt = rel_tg;
                end
            end
            OP_ADD: begin
                acc_we = 1'b1;
                acc_wd = sum[7:0];
                psw_we = 1'b1;
                psw_wd[PSW_CY] = sum[8];
                psw_wd[PSW_AC] = lo_sum[4];
                psw_wd[PSW_OV] = ov;
                rdata_nxt = sum[7:0];
            end
            OP_NIBBLE_EXCHANGE_OP: begin
                ram_we = 1'b1;
                ram_wa = ind_at;
                ram_wd = {ram_r[ind_at][7:4], acc_w[3:0]};
                acc_we = 1'b1;
                acc_wd = {acc_w[7:4], ram_r[ind_at][3:0]};
                rdata_nxt = acc_wd;
            end
            OP_DECREMENT_JUMP_NONZERO: begin
                ram_we = 1'b1;
                ram_wa = reg_at;
                ram_wd = dec;
                br_nxt = dec != 8'h00;
                tgt_nxt = rel_tg;
                rdata_nxt = dec;
            end
            OP_COMPARE_JUMP_UNEQUAL: begin
                br_nxt = acc_w != opnd;
                tgt_nxt = rel_tg;
            end
            OP_JMPI: begin
                br_nxt = 1'b1;
                tgt_nxt = data_pointer16 + {8'h00, acc_w};
            end
            OP_LONG_CALL_OP, OP_INTERRUPT_RETURN_OP: begin
                br_nxt = 1'b1;
                tgt_nxt = req_target;
            end
            default: begin
                rdata_nxt = opnd;
            end
        endcase
    end

    // RAM holds data only, so it carries no reset.
    always_ff @(posedge mclk) begin
        if (take && ram_we) begin
            ram_r[ram_wa] <= ram_wd;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < CSM_NSFR; i++) begin
                sfr_r[i] <= CSM_SFR_RESET;
            end
        end else if (take) begin
            if (sfr_we) begin
                sfr_r[sfr_ws] <= sfr_wd;
            end
            if (acc_we) begin
                sfr_r[SLOT_ACC] <= acc_wd;
            end
            if (psw_we) begin
                sfr_r[SLOT_PSW] <= psw_wd;
            end
        end
    end

    // Two-cycle operations hold busy for one extra edge before done.
    wire logic two_cyc = cost[1:0] == 2'h2;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            branch_r <= 1'b0;
            target_r <= 16'h0000;
            op_bytes_r <= 2'h0;
            op_cycles_r <= 2'h0;
        end else begin
            done_r <= (take && !two_cyc) || state_r == ST_HOLD;
            busy_r <= take && two_cyc;
            state_r <= (take && two_cyc) ? ST_HOLD : ST_IDLE;
            if (take) begin
                rdata_r <= rdata_nxt;
                branch_r <= br_nxt;
                target_r <= tgt_nxt;
                op_bytes_r <= cost[3:2];
                op_cycles_r <= cost[1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flash_sel_r <= 1'b0;
            fetch_fault_r <= 1'b0;
        end else begin
            flash_sel_r <= fetch_req && fetch_addr <= CSM_FLASH_TOP;
            fetch_fault_r <= fetch_req && fetch_addr > CSM_FLASH_TOP;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sfr_indirect_a: assert property (
        take && req_op == OP_WR && req_mode == M_IND && ind_at[7]
        |=> acc_w == $past(acc_w) && psw_w == $past(psw_w))
        else $error("indirect write disturbed a special register");
    upper_ram_a: assert property (
        take && req_op == OP_RD && req_mode == M_IND && ind_at[7]
        |=> rdata_r == $past(ram_r[ind_at]))
        else $error("indirect read of upper RAM wrong");
    lower_direct_a: assert property (
        take && req_op == OP_WR && req_mode == M_DIR && !req_addr[7]
        |=> ram_r[$past(req_addr)] == $past(req_wdata))
        else $error("direct write to lower RAM lost");
    bank_map_a: assert property (
        take && req_op == OP_RD && req_mode == M_REG
        |=> rdata_r == $past(ram_r[{3'b000, psw_w[4:3], req_reg}]))
        else $error("working register not taken from active bank");
    bit_region_a: assert property (
        take && req_op == OP_BSET && !req_bit[7]
        |=> ram_r[$past(bit_byte)][$past(req_bit[2:0])]
            && $past(bit_byte) >= CSM_BIT_BASE
            && $past(bit_byte) <= CSM_BIT_TOP)
        else $error("bit set outside bit region");
    psw_write_a: assert property (
        take && req_op == OP_WR && req_mode == M_DIR
        && req_addr == CSM_PROGRAM_STATUS_WORD
        |=> psw_w[7:1] == $past(req_wdata[7:1]))
        else $error("status word write lost");
    half_carry_a: assert property (
        take && req_op == OP_ADD
        |=> psw_w[PSW_AC] == ($past(lo_sum) >= 5'h10))
        else $error("half carry wrong");
    jump_ind_a: assert property (
        take && req_op == OP_JMPI
        |=> branch_r && target_r == $past(data_pointer16) + {8'h00, $past(acc_w)})
        else $error("indirect jump target wrong");
    flash_range_a: assert property (
        fetch_req |=> flash_sel_r == ($past(fetch_addr) <= CSM_FLASH_TOP)
        && fetch_fault_r != flash_sel_r)
        else $error("fetch range decode wrong");
    two_cycle_a: assert property (
        take && req_op inside {OP_INTERRUPT_RETURN_OP, OP_LONG_CALL_OP, OP_JBC, OP_DECREMENT_JUMP_NONZERO, OP_COMPARE_JUMP_UNEQUAL,
        OP_JMPI} |=> busy_r && !done_r && op_cycles_r == 2'h2
        ##1 done_r && !busy_r)
        else $error("two-cycle operation timing wrong");
    long_call_a: assert property (
        take && req_op == OP_LONG_CALL_OP
        |=> branch_r && target_r == $past(req_target) && op_bytes_r == 2'h3)
        else $error("long call target or size wrong");
    jbc_clear_a: assert property (
        take && req_op == OP_JBC && bit_val && !req_bit[7]
        |=> branch_r && !ram_r[$past(bit_byte)][$past(req_bit[2:0])])
        else $error("jump-bit-clear did not branch and clear");
    nibble_swap_a: assert property (
        take && req_op == OP_NIBBLE_EXCHANGE_OP
        |=> acc_w == {$past(acc_w[7:4]), $past(ram_r[ind_at][3:0])}
        && done_r && op_cycles_r == 2'h1)
        else $error("nibble exchange wrong");
    decrement_jump_nonzero_reg_a: assert property (
        take && req_op == OP_DECREMENT_JUMP_NONZERO
        |=> branch_r == ($past(ram_r[reg_at]) != 8'h01))
        else $error("decrement branch decision wrong");
    compare_jump_unequal_branch_a: assert property (
        take && req_op == OP_COMPARE_JUMP_UNEQUAL
        |=> branch_r == ($past(acc_w) != $past(opnd)))
        else $error("compare branch decision wrong");
    parity_live_a: assert property (
        take && req_op == OP_RD && req_mode == M_DIR
        && req_addr == CSM_PROGRAM_STATUS_WORD
        |=> rdata_r[PSW_P] == ^$past(acc_w))
        else $error("parity flag does not follow accumulator");
    unmapped_zero_a: assert property (
        take && req_op == OP_RD && dir_sfr && !dslot[5]
        |=> rdata_r == 8'h00)
        else $error("unmapped special address read nonzero");

    jbc_taken_c: cover property (take && req_op == OP_JBC && bit_val);
    decrement_jump_nonzero_loop_c: cover property (take && req_op == OP_DECREMENT_JUMP_NONZERO && dec != 8'h00);
    upper_wr_c: cover property (
        take && req_op == OP_WR && req_mode == M_IND && ind_at[7]);

endmodule : csm_core_map

// *** sim/core_sfr_and_memory_map_test.sv ***
/*
 * Self-checking bench of the core map block: register map, banks, bit
 * space, indirect upper RAM, status word, data pointer, jump and fetch.
 * Assumes the csm_pkg package and csm_core_map are compiled first.
 */
`timescale 1ns/1ps
module core_sfr_and_memory_map_test;
    import csm_pkg::*;

    typedef struct packed {
        logic [1:0]  kind;
        logic [7:0]  rd;
        logic [15:0] tg;
        logic [4:0]  fl;
    } csm_exp_t;

    localparam csm_exp_t NONE = '0;

    logic        mclk       = 1'b0;
    logic        rst        = 1'b1;
    logic        req_valid  = 1'b0;
    csm_op_t     req_op     = OP_RD;
    csm_mode_t   req_mode   = M_DIR;
    logic [7:0]  req_addr   = 8'h00;
    logic [2:0]  req_reg    = 3'h0;
    logic [7:0]  req_bit    = 8'h00;
    logic [7:0]  req_wdata  = 8'h00;
    logic [7:0]  req_rel    = 8'h00;
    logic [15:0] req_pc     = 16'h0000;
    logic [15:0] req_target = 16'h0000;
    logic        fetch_req  = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic        busy_r, done_r, branch_r, flash_sel_r, fetch_fault_r;
    logic [7:0]  rdata_r;
    logic [15:0] target_r;
    logic [1:0]  op_bytes_r, op_cycles_r;
    csm_exp_t    exp_q[$];
    int          mismatches = 0;
    int          n_compared = 0;
    logic [31:0] seed       = 32'hCE7F2B5F;
    logic [7:0]  dl, dh, acc, pv;

    always #2.5 mclk = ~mclk;

    csm_core_map dut (
        .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_op(req_op),
        .req_mode(req_mode), .req_addr(req_addr), .req_reg(req_reg),
        .req_bit(req_bit), .req_wdata(req_wdata), .req_rel(req_rel),
        .req_pc(req_pc), .req_target(req_target), .busy_r(busy_r),
        .done_r(done_r), .rdata_r(rdata_r), .branch_r(branch_r),
        .target_r(target_r), .op_bytes_r(op_bytes_r),
        .op_cycles_r(op_cycles_r), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .flash_sel_r(flash_sel_r),
        .fetch_fault_r(fetch_fault_r));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    function automatic csm_exp_t ex_rd(input logic [7:0] v);
        return '{2'h1, v, 16'h0000, 5'h00};
    endfunction : ex_rd

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("Error at %0t: byte %h, expected %h", $time, got, want);
        end
    endtask : cmp_byte

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            mismatches++;
            $display("Error at %0t: word %h, expected %h", $time, got, want);
        end
    endtask : cmp_word

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // One request, held over its taking edge; two-cycle ops block the next.
    task automatic go(input csm_op_t op, input csm_mode_t m,
                      input logic [7:0] a, input logic [7:0] d,
                      input csm_exp_t e);
        int n;
        @(negedge mclk);
        req_op    = op;
        req_mode  = m;
        req_addr  = a;
        req_reg   = a[2:0];
        req_bit   = a;
        req_wdata = d;
        req_valid = 1'b1;
        exp_q.push_back(e);
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        while (busy_r === 1'b1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        if (n == 8) begin
            mismatches++;
            complete_run();
        end
    endtask : go

    always @(negedge mclk) begin
        csm_exp_t e;
        if (done_r === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("Error at %0t: completion with nothing pending", $time);
            end else begin
                e = exp_q.pop_front();
                if (e.kind[0])
                    cmp_byte(rdata_r, e.rd);
                if (e.kind[1])
                    cmp_word(target_r, e.tg);
                if (e.kind[1])
                    cmp_word({11'h0, branch_r, op_bytes_r, op_cycles_r},
                             {11'h0, e.fl});
            end
        end
    end

    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (4) @(negedge mclk);
        rst  = 1'b0;
        seed = xs(seed);
        {pv, acc, dh, dl} = seed;
        go(OP_WR, M_DIR, 8'h82, dl, NONE);
        go(OP_WR, M_DIR, 8'h83, dh, NONE);
        go(OP_WR, M_DIR, 8'hE0, acc, NONE);
        go(OP_RD, M_DIR, 8'h82, 8'h00, ex_rd(dl));
        go(OP_RD, M_DIR, 8'h83, 8'h00, ex_rd(dh));
        // Stored parity bit is set on purpose; the read must ignore it.
        go(OP_WR, M_DIR, 8'hD0, 8'hE9, NONE);
        go(OP_RD, M_DIR, 8'hD0, 8'h00, ex_rd({7'h74, ^acc}));
        go(OP_WR, M_REG, 8'h03, pv, NONE);
        go(OP_RD, M_DIR, 8'h0B, 8'h00, ex_rd(pv));
        go(OP_WR, M_DIR, 8'h08, 8'h90, NONE);
        go(OP_WR, M_DIR, 8'h90, dl, NONE);
        go(OP_WR, M_IND, 8'h00, ~dl, NONE);
        go(OP_RD, M_DIR, 8'h90, 8'h00, ex_rd(dl));
        go(OP_RD, M_IND, 8'h00, 8'h00, ex_rd(~dl));
        go(OP_WR, M_DIR, 8'h84, pv, NONE);
        go(OP_RD, M_DIR, 8'h84, 8'h00, ex_rd(8'h00));
        go(OP_WR, M_DIR, 8'h21, 8'h00, NONE);
        go(OP_BSET, M_DIR, 8'h0A, 8'h00, NONE);
        go(OP_RD, M_DIR, 8'h21, 8'h00, ex_rd(8'h04));
        go(OP_JMPI, M_DIR, 8'h00, 8'h00,
           '{2'h2, 8'h00, {dh, dl} + {8'h00, acc}, 5'h16});
        // Half carry: 0Fh plus 01h carries out of bit 3 only.
        go(OP_WR, M_DIR, 8'hE0, 8'h0F, NONE);
        go(OP_WR, M_DIR, 8'h30, 8'h01, NONE);
        go(OP_ADD, M_DIR, 8'h30, 8'h00, ex_rd(8'h10));
        go(OP_RD, M_DIR, 8'hD0, 8'h00, ex_rd(8'h69));
        go(OP_NIBBLE_EXCHANGE_OP, M_IND, 8'h00, 8'h00,
           ex_rd({4'h1, ~dl[3:0]}));
        go(OP_RD, M_IND, 8'h00, 8'h00, ex_rd({~dl[7:4], 4'h0}));
        req_pc  = 16'h0100;
        req_rel = 8'hFE;
        go(OP_WR, M_REG, 8'h03, 8'h02, NONE);
        go(OP_DECREMENT_JUMP_NONZERO, M_REG, 8'h03, 8'h00,
           '{2'h3, 8'h01, 16'h00FE, 5'h1A});
        go(OP_DECREMENT_JUMP_NONZERO, M_REG, 8'h03, 8'h00,
           '{2'h3, 8'h00, 16'h00FE, 5'h0A});
        go(OP_JBC, M_DIR, 8'h0A, 8'h00,
           '{2'h3, 8'h01, 16'h00FE, 5'h1E});
        go(OP_RD, M_DIR, 8'h21, 8'h00, ex_rd(8'h00));
        go(OP_COMPARE_JUMP_UNEQUAL, M_DIR, 8'h30, 8'h00,
           '{2'h3, 8'h01, 16'h00FE, 5'h1E});
        req_target = {dh, pv};
        go(OP_LONG_CALL_OP, M_DIR, 8'h30, 8'h00,
           '{2'h2, 8'h00, {dh, pv}, 5'h1E});
        go(OP_INTERRUPT_RETURN_OP, M_DIR, 8'h30, 8'h00,
           '{2'h2, 8'h00, {dh, pv}, 5'h16});
        for (int i = 0; i < 2; i++) begin
            @(negedge mclk);
            fetch_req  = 1'b1;
            fetch_addr = 16'h1FFF + 16'(i);
            @(negedge mclk);
            cmp_word({14'h0, flash_sel_r, fetch_fault_r},
                     (i == 0) ? 16'h0002 : 16'h0001);
        end
        fetch_req = 1'b0;
        repeat (2) @(negedge mclk);
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("Error at %0t: results still pending", $time);
        end
        complete_run();
    end

endmodule : core_sfr_and_memory_map_test
